// File: verilog/system_reset_and_clock_out.sv
// Purpose: System reset distribution, software resets, reset cause, crystal check counter and clock-out select.
// Assumes: AHB-Lite slave on hclk at 125 MHz; hmaster names the core of the current address phase.
// Notes:   Clock inputs are only sampled by synchronisers or passed through the output mux.
// What this block does
// - Primary system reset also resets other subsystems.
// - Peripheral soft resets writable by primary core only.
// - Comm manager owns its own peripheral reset registers.
// - External reset write drives pin low 512 oscillator cycles.
// - Writing one to core field resets primary core.
// - Cause clear writes clear latched cause bits.
// - Crystal pulses counted, saturating at 0x3FF.
// - Counter clear bit returns count to zero.
// - Clock-out select field is four bits.
// - Select codes zero to six pick listed clocks.
// - Codes seven, eight, twelve, thirteen; rest reserved.
// - Selected clock also feeds output crossbar input.
`timescale 1ns/1ps
`include "sysctl_defs.svh"

module system_reset_and_clock_out (
  input  logic                            hclk,
  input  logic                            hresetn,
  input  logic                            hsel,
  input  logic [31:0]                     haddr,
  input  logic [1:0]                      htrans,
  input  logic                            hwrite,
  input  logic [2:0]                      hsize,
  input  logic [31:0]                     hwdata,
  input  logic                            hready,
  input  sysctl_pkg::bus_master_t         hmaster,
  output logic [31:0]                     hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  logic                            subsystem_reset_low,
  output logic                            second_core_reset_low,
  output logic                            comm_manager_reset_low,
  output logic [63:0]                     peripheral_soft_reset_regs,
  output logic [63:0]                     comm_manager_periph_reset_regs,
  output logic                            external_reset_pin_out,
  output logic                            external_reset_pin_oe,
  output logic                            primary_core_reset_req,
  input  logic [`CAUSE_EVENT_WIDTH-1:0]   reset_cause_events,
  input  logic                            crystal_clock,
  input  logic                            system_pll_out_clock,
  input  logic                            system_pll_clock,
  input  logic                            primary_core_clock,
  input  logic                            second_core_clock,
  input  logic                            auxiliary_pll_clock,
  input  logic                            internal_osc_one,
  input  logic                            internal_osc_two,
  input  logic                            comm_manager_clock,
  input  logic                            raw_pll_clock,
  input  logic                            raw_auxiliary_pll_clock,
  output logic                            clock_output_pin,
  output logic                            output_crossbar_clock
);
  import sysctl_pkg::*;

  // Bus data-phase state.
  logic                       dp_write;
  logic                       dp_read;
  logic                       rd_done;
  logic [7:0]                 dp_addr;
  bus_master_t                dp_master;

  // Register storage.
  logic [31:0]                periph_reset0;
  logic [31:0]                periph_reset1;
  logic [31:0]                cm_reset0;
  logic [31:0]                cm_reset1;
  logic [`CAUSE_WIDTH-1:0]    reset_cause_status;
  logic [3:0]                 clock_out_source_select;
  ext_reset_state_t           ext_state;
  ext_reset_state_t           next_ext_state;

  // Counter results.
  logic [`COUNT_WIDTH-1:0]    crystal_pulse_counter;
  logic [`COUNT_WIDTH-1:0]    osc_count;
  logic                       osc_done;

  // Address phase is taken only for NONSEQ or SEQ with the bus ready.
  wire take = hsel & hready & htrans[1];

  // Reads get one wait state so the read data always come from a flop and
  // never race a write committed on the same edge.
  assign hreadyout = ~(dp_read & ~rd_done);
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write  <= 1'b0;
      dp_read   <= 1'b0;
      dp_addr   <= 8'h00;
      dp_master <= MASTER_PRIMARY;
    end else if (hreadyout) begin
      dp_write  <= take & hwrite;
      dp_read   <= take & ~hwrite;
      dp_addr   <= haddr[7:0];
      dp_master <= hmaster;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_done <= 1'b0;
    end else begin
      rd_done <= dp_read & ~rd_done;
    end
  end

  // Write decode in the data phase; ownership checks sit in the strobes.
  wire wr_periph0  = dp_write && (dp_addr == `ADDR_PERIPH_RESET0) && (dp_master == MASTER_PRIMARY);
  wire wr_periph1  = dp_write && (dp_addr == `ADDR_PERIPH_RESET1) && (dp_master == MASTER_PRIMARY);
  wire wr_cm0      = dp_write && (dp_addr == `ADDR_CM_PERIPH_RESET0) && (dp_master == MASTER_COMM);
  wire wr_cm1      = dp_write && (dp_addr == `ADDR_CM_PERIPH_RESET1) && (dp_master == MASTER_COMM);
  wire wr_sim      = dp_write && (dp_addr == `ADDR_SIM_RESET);
  wire wr_clear    = dp_write && (dp_addr == `ADDR_CAUSE_CLEAR);
  wire wr_xtal     = dp_write && (dp_addr == `ADDR_XTAL_COUNT);
  wire wr_clksel   = dp_write && (dp_addr == `ADDR_CLKOUT_SEL);

  wire sim_ext_start  = wr_sim && hwdata[`SIM_EXT_BIT];
  wire sim_core_reset = wr_sim && hwdata[`SIM_CORE_BIT];
  wire xtal_clear     = wr_xtal && hwdata[`XTAL_CLEAR_BIT];

  // Peripheral soft-reset registers of the primary core.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_reset0 <= `RESET_WORD;
      periph_reset1 <= `RESET_WORD;
    end else begin
      if (wr_periph0) begin
        periph_reset0 <= hwdata;
      end
      if (wr_periph1) begin
        periph_reset1 <= hwdata;
      end
    end
  end

  // The comm manager keeps its own set, independent of the primary core.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cm_reset0 <= `RESET_WORD;
      cm_reset1 <= `RESET_WORD;
    end else begin
      if (wr_cm0) begin
        cm_reset0 <= hwdata;
      end
      if (wr_cm1) begin
        cm_reset1 <= hwdata;
      end
    end
  end

  assign peripheral_soft_reset_regs     = {periph_reset1, periph_reset0};
  assign comm_manager_periph_reset_regs = {cm_reset1, cm_reset0};

  // Subsystem resets follow the primary system reset without any clock, so
  // they hold even while hclk is stopped.
  assign second_core_reset_low  = subsystem_reset_low;
  assign comm_manager_reset_low = subsystem_reset_low;

  // Core reset request is a registered one-cycle pulse.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      primary_core_reset_req <= 1'b0;
    end else begin
      primary_core_reset_req <= sim_core_reset;
    end
  end

  // External reset drive, timed in oscillator-one edges. A new request while
  // the pin is already driven is ignored rather than stretching the pulse.
  always_comb begin
    next_ext_state = ext_state;
    case (ext_state)
      EXT_IDLE: begin
        if (sim_ext_start) begin
          next_ext_state = EXT_DRIVE;
        end
      end
      EXT_DRIVE: begin
        if (osc_done) begin
          next_ext_state = EXT_IDLE;
        end
      end
      default: begin
        next_ext_state = EXT_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_state <= EXT_IDLE;
    end else begin
      ext_state <= next_ext_state;
    end
  end

  // Open-drain pin: only ever pulled low.
  assign external_reset_pin_out = 1'b0;
  assign external_reset_pin_oe  = (ext_state == EXT_DRIVE);

  // The oscillator count is held at zero while idle, so each drive starts fresh.
  edge_pulse_counter #(
    .WIDTH (`COUNT_WIDTH),
    .LIMIT (`EXT_RESET_OSC_CYCLES)
  ) osc_timer (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .pulse_in (internal_osc_one),
    .clear    (ext_state == EXT_IDLE),
    .count    (osc_count),
    .at_limit (osc_done)
  );

  // Crystal check counter; software polls it before switching to the crystal.
  edge_pulse_counter #(
    .WIDTH (`COUNT_WIDTH),
    .LIMIT (`XTAL_COUNT_MAX)
  ) xtal_counter (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .pulse_in (crystal_clock),
    .clear    (xtal_clear),
    .count    (crystal_pulse_counter),
    .at_limit ()
  );

  // Reset cause: a new cause in the same cycle as its clear is kept.
  wire [`CAUSE_WIDTH-1:0] cause_set  = {reset_cause_events, sim_core_reset, sim_ext_start};
  wire [`CAUSE_WIDTH-1:0] cause_mask = wr_clear ? hwdata[`CAUSE_WIDTH-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_cause_status <= '0;
    end else begin
      reset_cause_status <= (reset_cause_status & ~cause_mask) | cause_set;
    end
  end

  // Clock-out select.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_out_source_select <= `CLKSEL_RESET;
    end else if (wr_clksel) begin
      clock_out_source_select <= hwdata[3:0];
    end
  end

  // Reserved codes give a quiet low output. The mux is not glitch-free; switch
  // the source only while the pin is not being used.
  wire [15:0] clock_sources = {
    1'b0,
    1'b0,
    raw_auxiliary_pll_clock,
    raw_pll_clock,
    1'b0,
    1'b0,
    1'b0,
    comm_manager_clock,
    crystal_clock,
    internal_osc_two,
    internal_osc_one,
    auxiliary_pll_clock,
    second_core_clock,
    primary_core_clock,
    system_pll_clock,
    system_pll_out_clock
  };

  assign clock_output_pin      = clock_sources[clock_out_source_select];
  assign output_crossbar_clock = clock_output_pin;

  // Read multiplexer; unmapped offsets read as zero.
  wire [31:0] read_value =
    (dp_addr == `ADDR_PERIPH_RESET0)    ? periph_reset0 :
    (dp_addr == `ADDR_PERIPH_RESET1)    ? periph_reset1 :
    (dp_addr == `ADDR_CM_PERIPH_RESET0) ? cm_reset0 :
    (dp_addr == `ADDR_CM_PERIPH_RESET1) ? cm_reset1 :
    (dp_addr == `ADDR_CAUSE_STATUS)     ? {{(32-`CAUSE_WIDTH){1'b0}}, reset_cause_status} :
    (dp_addr == `ADDR_XTAL_COUNT)       ? {{(32-`COUNT_WIDTH){1'b0}}, crystal_pulse_counter} :
    (dp_addr == `ADDR_CLKOUT_SEL)       ? {28'h0000000, clock_out_source_select} :
    32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (dp_read && !rd_done) begin
      hrdata <= read_value;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_subsys_reset_tie: assert property (
    !subsystem_reset_low |-> (!second_core_reset_low && !comm_manager_reset_low))
    else $error("subsystem reset did not reach the other subsystems");

  a_periph_guard: assert property (
    (dp_write && (dp_addr == `ADDR_PERIPH_RESET0) && (dp_master != MASTER_PRIMARY)) |=> $stable(periph_reset0))
    else $error("peripheral reset changed by a non-primary core");

  a_periph_high_guard: assert property (
    (dp_write && (dp_addr == `ADDR_PERIPH_RESET1) && (dp_master != MASTER_PRIMARY)) |=> $stable(periph_reset1))
    else $error("upper peripheral reset changed by a non-primary core");

  a_cm_guard: assert property (
    (dp_write && (dp_addr == `ADDR_CM_PERIPH_RESET0) && (dp_master != MASTER_COMM)) |=> $stable(cm_reset0))
    else $error("comm manager reset changed by another core");

  a_cm_reg_write: assert property (
    wr_cm0 |=> (cm_reset0 == $past(hwdata)))
    else $error("comm manager reset register did not take its write");

  a_ext_start: assert property (
    (sim_ext_start && ext_state == EXT_IDLE) |=> external_reset_pin_oe)
    else $error("external reset pin not driven after request");

  a_ext_span: assert property (
    $fell(external_reset_pin_oe) |-> ($past(osc_count) == `EXT_RESET_OSC_CYCLES))
    else $error("external reset released at the wrong oscillator count");

  a_core_pulse: assert property (
    sim_core_reset |=> primary_core_reset_req ##1 !primary_core_reset_req)
    else $error("core reset request is not a single pulse");

  a_cause_clear: assert property (
    (wr_clear && (hwdata[`CAUSE_WIDTH-1:0] == 8'hff) && (cause_set == '0)) |=> (reset_cause_status == '0))
    else $error("reset cause not cleared");

  a_clkout_default: assert property (
    (clock_out_source_select == `CLKSEL_PLL_SYS_OUT) |-> (clock_output_pin == system_pll_out_clock))
    else $error("default clock-out source wrong");

  a_clkout_raw: assert property (
    (clock_out_source_select == `CLKSEL_RAW_PLL) |-> (clock_output_pin == raw_pll_clock))
    else $error("raw clock-out source wrong");

  a_xbar_follow: assert property (
    output_crossbar_clock == clock_output_pin)
    else $error("crossbar clock differs from clock-out");

endmodule

// File: inc/sysctl_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the system reset and clock-out block.
// Assumes: Register offsets are byte addresses on a 32-bit AHB-Lite bus, decoded on haddr[7:0].
// Notes:   Definitions only; included by bare name.
`ifndef SYSCTL_DEFS_SVH
`define SYSCTL_DEFS_SVH

`define ADDR_PERIPH_RESET0     8'h00
`define ADDR_PERIPH_RESET1     8'h04
`define ADDR_CM_PERIPH_RESET0  8'h08
`define ADDR_CM_PERIPH_RESET1  8'h0c
`define ADDR_SIM_RESET         8'h10
`define ADDR_CAUSE_STATUS      8'h14
`define ADDR_CAUSE_CLEAR       8'h18
`define ADDR_XTAL_COUNT        8'h1c
`define ADDR_CLKOUT_SEL        8'h20

`define SIM_EXT_BIT            0
`define SIM_CORE_BIT           1
`define XTAL_CLEAR_BIT         16

`define CAUSE_WIDTH            8
`define CAUSE_EVENT_WIDTH      6
`define CAUSE_SIM_EXT_BIT      0
`define CAUSE_SIM_CORE_BIT     1

`define COUNT_WIDTH            10
`define XTAL_COUNT_MAX         10'h3ff
`define EXT_RESET_OSC_CYCLES   10'h200

`define RESET_WORD             32'h0000_0000
`define CLKSEL_RESET           4'h0

`define CLKSEL_PLL_SYS_OUT     4'h0
`define CLKSEL_SYS_PLL         4'h1
`define CLKSEL_PRIMARY_SYS     4'h2
`define CLKSEL_SECOND_SYS      4'h3
`define CLKSEL_AUX_PLL         4'h4
`define CLKSEL_OSC_ONE         4'h5
`define CLKSEL_OSC_TWO         4'h6
`define CLKSEL_XTAL            4'h7
`define CLKSEL_COMM_MGR        4'h8
`define CLKSEL_RAW_PLL         4'hc
`define CLKSEL_RAW_AUX_PLL     4'hd

`endif

// File: inc/sysctl_pkg.sv
// Purpose: Types shared by the system reset and clock-out block.
// Assumes: The bus fabric reports which core owns the current address phase.
// Notes:   Numeric constants live in sysctl_defs.svh.
package sysctl_pkg;

  typedef enum logic [1:0] {
    MASTER_PRIMARY,
    MASTER_SECOND,
    MASTER_COMM
  } bus_master_t;

  typedef enum logic {
    EXT_IDLE,
    EXT_DRIVE
  } ext_reset_state_t;

endpackage

// File: verilog/edge_pulse_counter.sv
// Purpose: Counts rising edges of a foreign clock in the hclk domain, saturating at a limit.
// Assumes: The counted clock runs well below half of hclk.
// Notes:   Three-stage synchroniser; only the second and third stages are compared.
`timescale 1ns/1ps
`include "sysctl_defs.svh"

module edge_pulse_counter #(
  parameter int                     WIDTH = `COUNT_WIDTH,
  parameter logic [`COUNT_WIDTH-1:0] LIMIT = `XTAL_COUNT_MAX
) (
  input  logic             hclk,
  input  logic             hresetn,
  input  logic             pulse_in,
  input  logic             clear,
  output logic [WIDTH-1:0] count,
  output logic             at_limit
);

  logic sync1;
  logic sync2;
  logic sync3;
  wire  rising = sync2 & ~sync3;

  // The first stage may be metastable, so only the second stage reads it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= pulse_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign at_limit = (count == LIMIT[WIDTH-1:0]);

  // Clear wins over a coincident edge; an edge at the limit is dropped.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (rising && !at_limit) begin
      count <= count + WIDTH'(1);
    end
  end

  a_count_limit: assert property (@(posedge hclk) disable iff (!hresetn)
    (at_limit && !clear) |=> at_limit)
    else $error("counter left its limit without a clear");

  a_count_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    clear |=> (count == '0))
    else $error("counter not zero after clear");

  a_count_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (!clear && !rising) |=> $stable(count))
    else $error("counter moved without a synchronised edge");

endmodule

// File: verification/test_system_reset_and_clock_out.sv
// Purpose: Self-checking bench for the system reset and clock-out block.
// Assumes: One AHB-Lite master; hready is looped from hreadyout; all clocks come from the bench.
// Notes:   Random data from a fixed seed, with corner cases written by hand among it.
`timescale 1ns/1ps
`include "sysctl_defs.svh"

module test_system_reset_and_clock_out;
  import sysctl_pkg::*;

  logic                          hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]                   haddr, hwdata, hrdata, rdat, d, mk;
  logic [1:0]                    htrans;
  logic [2:0]                    hsize;
  bus_master_t                   hmaster;
  logic                          subsystem_reset_low, second_core_reset_low, comm_manager_reset_low;
  logic [63:0]                   peripheral_soft_reset_regs, comm_manager_periph_reset_regs;
  logic                          external_reset_pin_out, external_reset_pin_oe, primary_core_reset_req;
  logic [`CAUSE_EVENT_WIDTH-1:0] reset_cause_events, ev;
  logic                          crystal_clock, system_pll_out_clock, system_pll_clock, primary_core_clock;
  logic                          second_core_clock, auxiliary_pll_clock, internal_osc_one, internal_osc_two;
  logic                          comm_manager_clock, raw_pll_clock, raw_auxiliary_pll_clock;
  logic                          clock_output_pin, output_crossbar_clock;
  logic [31:0]                   exp_r [4];
  logic [7:0]                    zero_regs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20};
  int                            num_errors, n_checks, seed, cnt;

  system_reset_and_clock_out dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hmaster(hmaster), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .subsystem_reset_low(subsystem_reset_low),
    .second_core_reset_low(second_core_reset_low), .comm_manager_reset_low(comm_manager_reset_low),
    .peripheral_soft_reset_regs(peripheral_soft_reset_regs),
    .comm_manager_periph_reset_regs(comm_manager_periph_reset_regs),
    .external_reset_pin_out(external_reset_pin_out), .external_reset_pin_oe(external_reset_pin_oe),
    .primary_core_reset_req(primary_core_reset_req), .reset_cause_events(reset_cause_events),
    .crystal_clock(crystal_clock), .system_pll_out_clock(system_pll_out_clock),
    .system_pll_clock(system_pll_clock), .primary_core_clock(primary_core_clock),
    .second_core_clock(second_core_clock), .auxiliary_pll_clock(auxiliary_pll_clock),
    .internal_osc_one(internal_osc_one), .internal_osc_two(internal_osc_two),
    .comm_manager_clock(comm_manager_clock), .raw_pll_clock(raw_pll_clock),
    .raw_auxiliary_pll_clock(raw_auxiliary_pll_clock), .clock_output_pin(clock_output_pin),
    .output_crossbar_clock(output_crossbar_clock)
  );

  always #4 hclk = ~hclk;

  // Foreign clocks start half a nanosecond late, so none of their edges meets an hclk edge or a sample point.
  initial begin
    {crystal_clock, system_pll_out_clock, system_pll_clock, primary_core_clock, second_core_clock} = '0;
    {auxiliary_pll_clock, internal_osc_one, internal_osc_two, comm_manager_clock} = '0;
    {raw_pll_clock, raw_auxiliary_pll_clock} = '0;
    #0.5;
    fork
      forever #12 crystal_clock = ~crystal_clock;
      forever #3 system_pll_out_clock = ~system_pll_out_clock;
      forever #5 system_pll_clock = ~system_pll_clock;
      forever #7 primary_core_clock = ~primary_core_clock;
      forever #9 second_core_clock = ~second_core_clock;
      forever #11 auxiliary_pll_clock = ~auxiliary_pll_clock;
      forever #20 internal_osc_one = ~internal_osc_one;
      forever #13 internal_osc_two = ~internal_osc_two;
      forever #17 comm_manager_clock = ~comm_manager_clock;
      forever #19 raw_pll_clock = ~raw_pll_clock;
      forever #23 raw_auxiliary_pll_clock = ~raw_auxiliary_pll_clock;
    join
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Ready is looked at on the falling edge, where it already equals what the next rising edge samples.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, input bus_master_t m);
    logic rdy;
    int   n;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hmaster <= m;
    for (int ph = 0; ph < 2; ph++) begin
      n = 0;
      do begin
        @(negedge hclk);
        rdy = hreadyout;
        rdat = hrdata;
        @(posedge hclk);
        n++;
      end while (rdy !== 1'b1 && n < 40);
      check("bus ready", 32'h1, 32'(rdy));
      check("bus response", 32'h0, 32'(hresp));
      if (ph == 0) begin
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd, input bus_master_t m = MASTER_PRIMARY);
    xfer(a, 1'b1, wd, m);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(a, 1'b0, 32'h0, MASTER_PRIMARY);
  endtask

  function automatic logic exp_clk(input logic [3:0] s);
    case (s)
      `CLKSEL_PLL_SYS_OUT: return system_pll_out_clock;
      `CLKSEL_SYS_PLL:     return system_pll_clock;
      `CLKSEL_PRIMARY_SYS: return primary_core_clock;
      `CLKSEL_SECOND_SYS:  return second_core_clock;
      `CLKSEL_AUX_PLL:     return auxiliary_pll_clock;
      `CLKSEL_OSC_ONE:     return internal_osc_one;
      `CLKSEL_OSC_TWO:     return internal_osc_two;
      `CLKSEL_XTAL:        return crystal_clock;
      `CLKSEL_COMM_MGR:    return comm_manager_clock;
      `CLKSEL_RAW_PLL:     return raw_pll_clock;
      `CLKSEL_RAW_AUX_PLL: return raw_auxiliary_pll_clock;
      default:             return 1'b0;
    endcase
  endfunction

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    hmaster = MASTER_PRIMARY;
    subsystem_reset_low = 1'b1;
    reset_cause_events = '0;
    num_errors = 0;
    n_checks = 0;
    seed = 32'h79073f41;
    exp_r = '{default: 32'h0};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(zero_regs[i]);
      check("reset value", `RESET_WORD, rdat);
    end
    check("reset pin enable", 32'h0, 32'(external_reset_pin_oe));
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      subsystem_reset_low <= i[0];
      @(negedge hclk);
      check("second core reset", 32'(i[0]), 32'(second_core_reset_low));
      check("comm manager reset", 32'(i[0]), 32'(comm_manager_reset_low));
    end
    for (int m = 0; m < 3; m++) begin
      for (int i = 0; i < 4; i++) begin
        d = $random(seed);
        wr(8'(i * 4), d, bus_master_t'(m));
        if ((i < 2 && m == 0) || (i >= 2 && m == 2)) exp_r[i] = d;
        rd(8'(i * 4));
        check("soft reset register", exp_r[i], rdat);
      end
    end
    check("periph reset low half", exp_r[0], peripheral_soft_reset_regs[31:0]);
    check("periph reset high half", exp_r[1], peripheral_soft_reset_regs[63:32]);
    check("comm reset low half", exp_r[2], comm_manager_periph_reset_regs[31:0]);
    check("comm reset high half", exp_r[3], comm_manager_periph_reset_regs[63:32]);
    wr(8'h40, $random(seed));
    rd(8'h40);
    check("unmapped read", 32'h0, rdat);
    wr(`ADDR_CAUSE_CLEAR, 32'hff);
    rd(`ADDR_CAUSE_STATUS);
    check("cause cleared", 32'h0, rdat);
    ev = 6'($random(seed)) | 6'h01;
    @(posedge hclk);
    reset_cause_events <= ev;
    @(posedge hclk);
    reset_cause_events <= '0;
    rd(`ADDR_CAUSE_STATUS);
    check("cause latched", {24'h0, ev, 2'b00}, rdat);
    mk = $random(seed) & 32'hff;
    wr(`ADDR_CAUSE_CLEAR, mk);
    rd(`ADDR_CAUSE_STATUS);
    check("cause after clear", {24'h0, ev, 2'b00} & ~mk, rdat);
    cnt = 0;
    fork
      wr(`ADDR_SIM_RESET, 32'h2);
      repeat (10) begin
        @(negedge hclk);
        cnt += (primary_core_reset_req === 1'b1);
      end
    join
    check("core reset pulse cycles", 32'h1, 32'(cnt));
    check("pin idle after core reset", 32'h0, 32'(external_reset_pin_oe));
    rd(`ADDR_CAUSE_STATUS);
    check("cause core bit", 32'h1, 32'(rdat[`CAUSE_SIM_CORE_BIT]));
    cnt = 0;
    // A second request lands mid-pulse; the low time must not restart.
    fork
      repeat (560) begin
        @(posedge internal_osc_one);
        cnt += (external_reset_pin_oe === 1'b1);
      end
      begin
        wr(`ADDR_SIM_RESET, 32'h1);
        @(negedge hclk);
        check("pin driven", 32'h1, 32'(external_reset_pin_oe));
        check("pin level", 32'h0, 32'(external_reset_pin_out));
        repeat (1000) @(posedge hclk);
        wr(`ADDR_SIM_RESET, 32'h1);
      end
    join
    check("osc cycles held low", 32'h1, 32'(cnt >= 510 && cnt <= 514));
    check("pin released", 32'h0, 32'(external_reset_pin_oe));
    repeat (1000) @(posedge hclk);
    rd(`ADDR_XTAL_COUNT);
    check("count saturated", 32'(`XTAL_COUNT_MAX), rdat);
    wr(`ADDR_XTAL_COUNT, 32'h1 << `XTAL_CLEAR_BIT);
    rd(`ADDR_XTAL_COUNT);
    check("count cleared", 32'h1, 32'(rdat <= 32'h4));
    repeat (1500) @(posedge hclk);
    rd(`ADDR_XTAL_COUNT);
    check("count rate", 32'h1, 32'(rdat >= 32'd496 && rdat <= 32'd506));
    repeat (2200) @(posedge hclk);
    rd(`ADDR_XTAL_COUNT);
    check("count saturated again", 32'(`XTAL_COUNT_MAX), rdat);
    for (int s = 0; s < 16; s++) begin
      wr(`ADDR_CLKOUT_SEL, 32'hffff_fff0 | 32'(s));
      rd(`ADDR_CLKOUT_SEL);
      check("select field", 32'(s), rdat);
      repeat (24) begin
        @(posedge hclk);
        #2.25;
        check("clock out", 32'(exp_clk(4'(s))), 32'(clock_output_pin));
        check("crossbar clock", 32'(exp_clk(4'(s))), 32'(output_crossbar_clock));
      end
    end
    end_sim();
  end

  // The sequence needs under 10000 hclk cycles; the limit leaves a wide margin.
  initial begin
    #400000;
    num_errors++;
    $display("BAD watchdog expected finish seen timeout");
    end_sim();
  end
endmodule
